// [logic/bnp_pkg.sv]
// Constants, register map and types for the byte/nibble port with low latch.
// Assumes a 40 MHz system clock and a 32-bit Avalon-MM register bus.
package bnp_pkg;

	localparam int unsigned CLOCK_MHZ   = 40;
	localparam int unsigned PINS        = 8;
	localparam int unsigned NIB_W       = 4;
	localparam int unsigned ADDR_W      = 6;

	// Low-detect sampling interval in ns, turned into whole clock cycles below
	localparam int unsigned LVL_SAMPLE_NS = 50;
	localparam int unsigned LVL_SAMPLE_CYC_RAW = (LVL_SAMPLE_NS * CLOCK_MHZ) / 1000;
	localparam int unsigned LVL_SAMPLE_CYC = (LVL_SAMPLE_CYC_RAW < 1) ? 1 : LVL_SAMPLE_CYC_RAW;

	// Register byte offsets
	localparam logic [5:0] OFS_CTRL      = 6'h00;
	localparam logic [5:0] OFS_BYTE_DATA = 6'h04;
	localparam logic [5:0] OFS_NIB_DATA  = 6'h08;
	localparam logic [5:0] OFS_LVL_EN    = 6'h0C;
	localparam logic [5:0] OFS_LVL_DATA  = 6'h10;
	localparam logic [5:0] OFS_INIT      = 6'h14;
	localparam logic [5:0] OFS_IRQ_MODE  = 6'h18;
	localparam logic [5:0] OFS_IRQ_STAT  = 6'h1C;
	localparam logic [5:0] OFS_IRQ_MASK  = 6'h20;

	// CTRL field positions
	localparam int unsigned CTRL_BYTE_EN   = 0;
	localparam int unsigned CTRL_BYTE_OUT  = 1;
	localparam int unsigned CTRL_NIB_EN    = 2;
	localparam int unsigned CTRL_NIB_OUT   = 3;
	localparam int unsigned CTRL_NIB_BASE  = 4;
	localparam int unsigned CTRL_PULLUP    = 7;
	localparam int unsigned CTRL_LOAD_INIT = 8;

	localparam logic [2:0] NIB_BASE_MAX = 3'h4;
	localparam logic [7:0] BYTE_INIT_RST = 8'h00;
	localparam logic [3:0] NIB_INIT_RST  = 4'h0;
	localparam logic [7:0] PULLUP_PINS   = 8'hF0;

	// Interrupt trigger modes, three bits per pin
	typedef enum logic [2:0] {
		BNP_IRQ_OFF  = 3'h0,
		BNP_IRQ_HIGH = 3'h1,
		BNP_IRQ_LOW  = 3'h2,
		BNP_IRQ_RISE = 3'h3,
		BNP_IRQ_FALL = 3'h4,
		BNP_IRQ_BOTH = 3'h5
	} bnp_irq_mode_t;

	typedef enum logic [1:0] {
		BNP_BUS_IDLE = 2'h1,
		BNP_BUS_ACK  = 2'h2
	} bnp_bus_st_t;

endpackage : bnp_pkg

// [logic/bnp_pin_event.sv]
// Per-pin interrupt event detector: level or edge, chosen by a mode code.
// Assumes the pin level is already synchronous to clock.
module bnp_pin_event (
	input  wire logic       clock,
	input  wire logic       rst_n,
	input  wire logic       pin,
	input  wire logic [2:0] mode,
	output logic            event_hit
);

	typedef struct packed {
		logic prev;
	} bnp_ev_state_t;

	bnp_ev_state_t st_reg;
	bnp_ev_state_t st_next;

	always_comb begin
		st_next.prev = pin;
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	// Independent of port direction: the pin level is watched whatever drives it
	always_comb begin
		case (mode)
			bnp_pkg::BNP_IRQ_HIGH: event_hit = pin;
			bnp_pkg::BNP_IRQ_LOW:  event_hit = ~pin;
			bnp_pkg::BNP_IRQ_RISE: event_hit = pin & ~st_reg.prev;
			bnp_pkg::BNP_IRQ_FALL: event_hit = ~pin & st_reg.prev;
			bnp_pkg::BNP_IRQ_BOTH: event_hit = pin ^ st_reg.prev;
			default:               event_hit = 1'b0;
		endcase
	end

endmodule : bnp_pin_event

// [logic/bnp_port.sv]
// Byte port, nibble port and low-detect latches on the low eight pins,
// with an Avalon-MM register slave and one level interrupt.
// Assumes pin inputs are synchronous to clock; pads resolve out/oe.
//
// How it works
// - Byte port uses pins 0-7, pin 0 LSB
// - Byte output starts at programmable init value
// - Each pin may latch short low pulses
// - Pin level sampled into latch each interval
// - Latch read returns one and clears it
// - Latch can set again right after clear
// - Persistent low keeps every read at one
// - Nibble port moves four pins at once
// - Nibble base pin 0..4, base is LSB
// - Nibble direction switchable at run time
// - Nibble output starts at programmable init value
// - Pin interrupts on level or edge modes
// - Pull-ups on pins 4-7 only when enabled
// - Inputs sampled at read, outputs driven at write
// - Byte port read or written as whole
module bnp_port #(
	parameter logic [7:0] BYTE_INIT = bnp_pkg::BYTE_INIT_RST,
	parameter logic [3:0] NIB_INIT  = bnp_pkg::NIB_INIT_RST
) (
	input  wire logic        clock,
	input  wire logic        rst_n,
	input  wire logic [5:0]  address,
	input  wire logic        read,
	input  wire logic        write,
	input  wire logic [3:0]  byteenable,
	input  wire logic [31:0] writedata,
	output logic [31:0]      readdata,
	output logic             waitrequest,
	input  wire logic [7:0]  gpio_in,
	output logic [7:0]       gpio_out,
	output logic [7:0]       gpio_oe,
	output logic [7:0]       pullup_en,
	output logic             irq
);

	typedef struct packed {
		bnp_pkg::bnp_bus_st_t bus;
		logic                 wait_n;
		logic [31:0]          rdata;
		logic                 byte_en;
		logic                 byte_dir_out;
		logic                 nib_en;
		logic                 nib_dir_out;
		logic [2:0]           nib_base;
		logic                 pull;
		logic [7:0]           byte_val;
		logic [3:0]           nib_val;
		logic [7:0]           byte_init;
		logic [3:0]           nib_init;
		logic [7:0]           lvl_en;
		logic [7:0]           lvl_latch;
		logic [23:0]          irq_mode;
		logic [7:0]           irq_stat;
		logic [7:0]           irq_mask;
		logic [7:0]           div_cnt;
		logic [7:0]           pin_out;
		logic [7:0]           pin_oe;
		logic [7:0]           pull_out;
		logic                 irq_out;
	} bnp_state_t;

	bnp_state_t st_reg;
	bnp_state_t st_next;

	logic [7:0] ev_hit;

	// Mask of the four pins the nibble port occupies
	function automatic logic [7:0] nib_mask(input logic [2:0] base);
		nib_mask = 8'(8'h0F << base);
	endfunction : nib_mask

	// Byte-lane merge of a write into a 32-bit register image
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
		merge = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				merge[i*8 +: 8] = wd[i*8 +: 8];
			end
		end
	endfunction : merge

	function automatic logic [31:0] ctrl_image(input bnp_state_t s);
		ctrl_image = '0;
		ctrl_image[bnp_pkg::CTRL_BYTE_EN]       = s.byte_en;
		ctrl_image[bnp_pkg::CTRL_BYTE_OUT]      = s.byte_dir_out;
		ctrl_image[bnp_pkg::CTRL_NIB_EN]        = s.nib_en;
		ctrl_image[bnp_pkg::CTRL_NIB_OUT]       = s.nib_dir_out;
		ctrl_image[bnp_pkg::CTRL_NIB_BASE +: 3] = s.nib_base;
		ctrl_image[bnp_pkg::CTRL_PULLUP]        = s.pull;
	endfunction : ctrl_image

	// Pure read decode; the latch clear stays with the caller so a read clears once
	function automatic logic [31:0] read_image(input logic [5:0] a, input bnp_state_t s, input logic [7:0] pins);
		case (a)
			bnp_pkg::OFS_CTRL: begin
				read_image = ctrl_image(s);
			end
			bnp_pkg::OFS_BYTE_DATA: begin
				read_image = {24'h0, pins};
			end
			bnp_pkg::OFS_NIB_DATA: begin
				read_image = {28'h0, 4'(pins >> s.nib_base)};
			end
			bnp_pkg::OFS_LVL_EN: begin
				read_image = {24'h0, s.lvl_en};
			end
			bnp_pkg::OFS_LVL_DATA: begin
				read_image = {24'h0, s.lvl_latch & s.lvl_en};
			end
			bnp_pkg::OFS_INIT: begin
				read_image = {20'h0, s.nib_init, s.byte_init};
			end
			bnp_pkg::OFS_IRQ_MODE: begin
				read_image = {8'h0, s.irq_mode};
			end
			bnp_pkg::OFS_IRQ_STAT: begin
				read_image = {24'h0, s.irq_stat};
			end
			bnp_pkg::OFS_IRQ_MASK: begin
				read_image = {24'h0, s.irq_mask};
			end
			default: begin
				read_image = '0;
			end
		endcase
	endfunction : read_image

	genvar g;
	generate
		for (g = 0; g < bnp_pkg::PINS; g++) begin : g_ev
			bnp_pin_event u_ev (
				.clock     (clock),
				.rst_n     (rst_n),
				.pin       (gpio_in[g]),
				.mode      (st_reg.irq_mode[g*3 +: 3]),
				.event_hit (ev_hit[g])
			);
		end
	endgenerate

	always_comb begin
		logic        take;
		logic        wr;
		logic        rd;
		logic        sample;
		logic [31:0] w;
		logic [31:0] rd_val;
		logic [7:0]  lvl_clr;
		logic [7:0]  nmask;
		logic [7:0]  nib_pins;
		logic [7:0]  out_n;
		logic [7:0]  oe_n;
		logic [7:0]  stat_clr;
		take     = 1'b0;
		wr       = 1'b0;
		rd       = 1'b0;
		sample   = 1'b0;
		w        = '0;
		rd_val   = '0;
		lvl_clr  = '0;
		nmask    = '0;
		nib_pins = '0;
		out_n    = '0;
		oe_n     = '0;
		stat_clr = '0;
		st_next  = st_reg;

		// Bus slave: take a request once, answer with waitrequest low one cycle
		take = (read | write) & (st_reg.bus == bnp_pkg::BNP_BUS_IDLE);
		wr   = take & write;
		rd   = take & read & ~write;
		case (st_reg.bus)
			bnp_pkg::BNP_BUS_IDLE: begin
				if (take) begin
					st_next.bus    = bnp_pkg::BNP_BUS_ACK;
					st_next.wait_n = 1'b1;
				end else begin
					st_next.wait_n = 1'b0;
				end
			end
			bnp_pkg::BNP_BUS_ACK: begin
				st_next.bus    = bnp_pkg::BNP_BUS_IDLE;
				st_next.wait_n = 1'b0;
			end
			default: begin
				st_next.bus    = bnp_pkg::BNP_BUS_IDLE;
				st_next.wait_n = 1'b0;
			end
		endcase

		// Sampling divider for the low-detect latches
		if (st_reg.div_cnt >= 8'(bnp_pkg::LVL_SAMPLE_CYC - 1)) begin
			st_next.div_cnt = '0;
			sample          = 1'b1;
		end else begin
			st_next.div_cnt = st_reg.div_cnt + 8'h01;
		end

		// Register writes
		if (wr) begin
			case (address)
				bnp_pkg::OFS_CTRL: begin
					w = merge(ctrl_image(st_reg), writedata, byteenable);
					st_next.byte_en      = w[bnp_pkg::CTRL_BYTE_EN];
					st_next.byte_dir_out = w[bnp_pkg::CTRL_BYTE_OUT];
					st_next.nib_en       = w[bnp_pkg::CTRL_NIB_EN];
					st_next.nib_dir_out  = w[bnp_pkg::CTRL_NIB_OUT];
					// Out-of-range base is refused; the old base stays
					if (w[bnp_pkg::CTRL_NIB_BASE +: 3] <= bnp_pkg::NIB_BASE_MAX) begin
						st_next.nib_base = w[bnp_pkg::CTRL_NIB_BASE +: 3];
					end
					st_next.pull = w[bnp_pkg::CTRL_PULLUP];
					if (byteenable[1] && writedata[bnp_pkg::CTRL_LOAD_INIT]) begin
						st_next.byte_val = st_reg.byte_init;
						st_next.nib_val  = st_reg.nib_init;
					end
				end
				bnp_pkg::OFS_BYTE_DATA: begin
					if (byteenable[0]) begin
						st_next.byte_val = writedata[7:0];
					end
				end
				bnp_pkg::OFS_NIB_DATA: begin
					if (byteenable[0]) begin
						st_next.nib_val = writedata[3:0];
					end
				end
				bnp_pkg::OFS_LVL_EN: begin
					if (byteenable[0]) begin
						st_next.lvl_en = writedata[7:0];
					end
				end
				bnp_pkg::OFS_INIT: begin
					w = merge({20'h0, st_reg.nib_init, st_reg.byte_init}, writedata, byteenable);
					st_next.byte_init = w[7:0];
					st_next.nib_init  = w[11:8];
				end
				bnp_pkg::OFS_IRQ_MODE: begin
					w = merge({8'h0, st_reg.irq_mode}, writedata, byteenable);
					st_next.irq_mode = w[23:0];
				end
				bnp_pkg::OFS_IRQ_STAT: begin
					if (byteenable[0]) begin
						stat_clr = writedata[7:0];
					end
				end
				bnp_pkg::OFS_IRQ_MASK: begin
					if (byteenable[0]) begin
						st_next.irq_mask = writedata[7:0];
					end
				end
				default: begin
				end
			endcase
		end

		// Register reads; pins sampled at the read itself
		if (rd) begin
			rd_val = read_image(address, st_reg, gpio_in);
			// Only a data read of the latches clears them; status reads leave them alone
			if (address == bnp_pkg::OFS_LVL_DATA) begin
				lvl_clr = st_reg.lvl_en;
			end
			st_next.rdata = rd_val;
		end else if (take) begin
			st_next.rdata = '0;
		end

		// Latch: a low seen at a sample sets it, and set wins over the read clear
		st_next.lvl_latch = (st_reg.lvl_latch & ~lvl_clr) |
			(sample ? (~gpio_in & st_reg.lvl_en) : 8'h00);

		// Interrupt status: set wins over a write-one clear
		st_next.irq_stat = (st_reg.irq_stat & ~stat_clr) | ev_hit;
		st_next.irq_out  = |(st_next.irq_stat & st_reg.irq_mask);

		// Pin ownership: byte port takes all eight pins over the nibble port
		nmask = nib_mask(st_next.nib_base);
		nib_pins = 8'({4'h0, st_next.nib_val} << st_next.nib_base);
		if (st_next.byte_en) begin
			out_n = st_next.byte_val;
			oe_n  = st_next.byte_dir_out ? 8'hFF : 8'h00;
		end else if (st_next.nib_en) begin
			out_n = nib_pins;
			oe_n  = st_next.nib_dir_out ? nmask : 8'h00;
		end
		// A pin watched by its low-detect latch is never driven
		oe_n = oe_n & ~st_next.lvl_en;
		st_next.pin_out  = out_n & oe_n;
		st_next.pin_oe   = oe_n;
		st_next.pull_out = st_next.pull ? bnp_pkg::PULLUP_PINS : 8'h00;
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			st_reg              <= '0;
			st_reg.bus          <= bnp_pkg::BNP_BUS_IDLE;
			st_reg.byte_val     <= BYTE_INIT;
			st_reg.nib_val      <= NIB_INIT;
			st_reg.byte_init    <= BYTE_INIT;
			st_reg.nib_init     <= NIB_INIT;
			st_reg.nib_base     <= 3'h0;
		end else begin
			st_reg <= st_next;
		end
	end

	// Waitrequest is high except the one answering cycle
	assign waitrequest = ~st_reg.wait_n;
	assign readdata    = st_reg.rdata;
	assign gpio_out    = st_reg.pin_out;
	assign gpio_oe     = st_reg.pin_oe;
	assign pullup_en   = st_reg.pull_out;
	assign irq         = st_reg.irq_out;

endmodule : bnp_port

// [verif/bnp_port_sva.sv]
// Checker for the byte/nibble port: bus answer timing, pin outputs, interrupt.
// Assumes one clock and the fixed one-cycle Avalon answer of the slave.
module bnp_port_chk (
	input wire logic        clock,
	input wire logic        rst_n,
	input wire logic        read,
	input wire logic        write,
	input wire logic        waitrequest,
	input wire logic [31:0] readdata,
	input wire logic [7:0]  gpio_out,
	input wire logic [7:0]  gpio_oe,
	input wire logic [7:0]  pullup_en,
	input wire logic        irq
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);
	a_wait_answer: assert property ((read || write) && waitrequest |=> !waitrequest)
		else $error("No answer one cycle after a request");
	a_wait_single: assert property (!waitrequest |=> waitrequest)
		else $error("Answer lasted more than one cycle");
	a_idle_quiet: assert property (!read && !write && waitrequest |=> waitrequest)
		else $error("Answer without a request");
	a_rdata_hold: assert property (waitrequest && $past(waitrequest) |-> $stable(readdata))
		else $error("Read data moved without a request");
	a_out_hold: assert property (!(write && waitrequest) |=> $stable(gpio_out) && $stable(gpio_oe))
		else $error("Pin outputs moved without a write");
	a_out_gated: assert property ((gpio_out & ~gpio_oe) == 8'h00)
		else $error("Output value on an undriven pin");
	a_pull_low: assert property (pullup_en == 8'h00 || pullup_en == 8'hF0)
		else $error("Pull-up request outside the pins 4 to 7 group");
	a_irq_clear: assert property ($fell(irq) |-> $past(write) || $past(write, 2))
		else $error("Interrupt dropped without a write");
endmodule : bnp_port_chk

bind bnp_port bnp_port_chk bnp_port_chk_i (
	.clock(clock), .rst_n(rst_n), .read(read), .write(write), .waitrequest(waitrequest),
	.readdata(readdata), .gpio_out(gpio_out), .gpio_oe(gpio_oe), .pullup_en(pullup_en), .irq(irq)
);

// [verif/bnp_pin_model.sv]
// Pins seen from outside: driven pads, external drivers, pull-ups, floating lines.
// Assumes the bench changes ext_val and ext_drv just after a clock edge.
module bnp_pin_model (
	input wire logic       clock,
	input wire logic [7:0] gpio_out,
	input wire logic [7:0] gpio_oe,
	input wire logic [7:0] pullup_en,
	input wire logic [7:0] ext_val,
	input wire logic [7:0] ext_drv,
	output logic [7:0]     gpio_in
);
	timeunit 1ns;
	timeprecision 100ps;
	// Floating pins toggle so a missing drive never reads as a lucky constant
	logic [7:0] float_reg = 8'h55;
	always @(posedge clock) float_reg <= ~float_reg;
	assign gpio_in = (gpio_oe & gpio_out) | (~gpio_oe & ext_drv & ext_val)
		| (~gpio_oe & ~ext_drv & (pullup_en | float_reg));
endmodule : bnp_pin_model

// [verif/bnp_port_tb.sv]
// Self-checking bench for the byte/nibble port with low latch.
// Assumes the slave answers each request and the pin model closes the pads.
module bnp_port_tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic        clock, rst_n, read, write, waitrequest, irq;
	logic [5:0]  address;
	logic [3:0]  byteenable;
	logic [31:0] writedata, readdata;
	logic [7:0]  gpio_in, gpio_out, gpio_oe, pullup_en, ext_val, ext_drv;
	int          errors, tests_run;

	bnp_port #(.BYTE_INIT(8'h5A), .NIB_INIT(4'h6)) bnp_port_i (
		.clock(clock), .rst_n(rst_n), .address(address), .read(read), .write(write),
		.byteenable(byteenable), .writedata(writedata), .readdata(readdata),
		.waitrequest(waitrequest), .gpio_in(gpio_in), .gpio_out(gpio_out),
		.gpio_oe(gpio_oe), .pullup_en(pullup_en), .irq(irq));
	bnp_pin_model bnp_pin_model_i (.clock(clock), .gpio_out(gpio_out), .gpio_oe(gpio_oe),
		.pullup_en(pullup_en), .ext_val(ext_val), .ext_drv(ext_drv), .gpio_in(gpio_in));

	always #12.5 clock = ~clock;

	task automatic wrap_up;
		$display("Comparisons %0d, mismatches %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : wrap_up

	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			errors++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check

	// One edge of gap before each request keeps a driver from assigning twice per step
	task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d, output logic [31:0] q);
		int n;
		@(posedge clock);
		address <= a;
		writedata <= d;
		byteenable <= 4'hF;
		write <= wr;
		read <= !wr;
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (waitrequest !== 1'b0 && n < 50);
		if (n >= 50) begin
			check("bus answer", 32'h0, 32'h1);
			wrap_up;
		end
		q = readdata;
		write <= 1'b0;
		read <= 1'b0;
	endtask : bus

	task automatic wr(input logic [5:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask : wr

	task automatic rd_chk(input string nm, input logic [5:0] a, input logic [31:0] e);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		check(nm, q, e);
	endtask : rd_chk

	task automatic pulse;
		ext_val <= 8'hFE;
		repeat (2) @(posedge clock);
		ext_val <= 8'hFF;
	endtask : pulse

	task automatic t_byte;
		wr(bnp_pkg::OFS_CTRL, 32'h3);
		check("byte init", {24'h0, gpio_out}, 32'h5A);
		check("byte oe", {24'h0, gpio_oe}, 32'hFF);
		wr(bnp_pkg::OFS_BYTE_DATA, 32'h1A5);
		check("byte out", {24'h0, gpio_out}, 32'hA5);
		rd_chk("byte readback", bnp_pkg::OFS_BYTE_DATA, 32'hA5);
		wr(bnp_pkg::OFS_CTRL, 32'h81);
		check("pullups", {24'h0, pullup_en}, 32'hF0);
		check("byte in oe", {24'h0, gpio_oe}, 32'h00);
		ext_drv <= 8'hFF;
		ext_val <= 8'h3C;
		rd_chk("byte in", bnp_pkg::OFS_BYTE_DATA, 32'h3C);
		rd_chk("unmapped", 6'h24, 32'h0);
	endtask : t_byte

	task automatic t_nib;
		wr(bnp_pkg::OFS_CTRL, 32'h0C);
		check("nib init", {24'h0, gpio_out}, 32'h06);
		for (int b = 0; b < 5; b++) begin
			wr(bnp_pkg::OFS_CTRL, 32'h0C | (b << 4));
			wr(bnp_pkg::OFS_NIB_DATA, 32'h39);
			check("nib oe", {24'h0, gpio_oe}, 32'h0F << b);
			check("nib out", {24'h0, gpio_out}, 32'h09 << b);
			ext_val <= 8'hA5;
			wr(bnp_pkg::OFS_CTRL, 32'h04 | (b << 4));
			rd_chk("nib in", bnp_pkg::OFS_NIB_DATA, (32'hA5 >> b) & 32'hF);
		end
		wr(bnp_pkg::OFS_CTRL, 32'h5C);
		check("nib base kept", {24'h0, gpio_oe}, 32'hF0);
	endtask : t_nib

	task automatic t_lvl;
		wr(bnp_pkg::OFS_CTRL, 32'h0);
		ext_val <= 8'hFF;
		wr(bnp_pkg::OFS_LVL_EN, 32'h1);
		pulse;
		rd_chk("short low", bnp_pkg::OFS_LVL_DATA, 32'h1);
		rd_chk("read clears", bnp_pkg::OFS_LVL_DATA, 32'h0);
		pulse;
		rd_chk("set again", bnp_pkg::OFS_LVL_DATA, 32'h1);
		ext_val <= 8'hFE;
		rd_chk("low held", bnp_pkg::OFS_LVL_DATA, 32'h1);
		rd_chk("low held", bnp_pkg::OFS_LVL_DATA, 32'h1);
		ext_val <= 8'hFF;
		wr(bnp_pkg::OFS_LVL_EN, 32'h0);
	endtask : t_lvl

	// Pin 1 walks through every trigger mode except off: stable high, falling, then rising
	task automatic t_irq;
		wr(bnp_pkg::OFS_IRQ_MASK, 32'h2);
		for (int m = 1; m < 6; m++) begin
			wr(bnp_pkg::OFS_IRQ_MODE, m << 3);
			wr(bnp_pkg::OFS_IRQ_STAT, 32'hFF);
			rd_chk("stat high", bnp_pkg::OFS_IRQ_STAT, {30'h0, m == 1, 1'b0});
			ext_val <= 8'hFD;
			repeat (2) @(posedge clock);
			rd_chk("stat fall", bnp_pkg::OFS_IRQ_STAT, {30'h0, m != 3, 1'b0});
			wr(bnp_pkg::OFS_IRQ_STAT, 32'hFF);
			ext_val <= 8'hFF;
			repeat (2) @(posedge clock);
			rd_chk("stat rise", bnp_pkg::OFS_IRQ_STAT, {30'h0, m != 4, 1'b0});
			check("irq", {31'h0, irq}, {31'h0, m != 4});
		end
		wr(bnp_pkg::OFS_IRQ_MASK, 32'h0);
		repeat (2) @(posedge clock);
		check("irq masked", {31'h0, irq}, 32'h0);
		wr(bnp_pkg::OFS_IRQ_MODE, 32'h0);
	endtask : t_irq

	// Load-init strobe, register readback, and low-detect pins released from drive
	task automatic t_init;
		wr(bnp_pkg::OFS_INIT, 32'hF9C3);
		rd_chk("init readback", bnp_pkg::OFS_INIT, 32'h9C3);
		wr(bnp_pkg::OFS_CTRL, 32'h103);
		check("byte load init", {24'h0, gpio_out}, 32'hC3);
		check("pullups off", {24'h0, pullup_en}, 32'h00);
		rd_chk("ctrl readback", bnp_pkg::OFS_CTRL, 32'h03);
		wr(bnp_pkg::OFS_CTRL, 32'h10C);
		check("nib load init", {24'h0, gpio_out}, 32'h09);
		wr(bnp_pkg::OFS_IRQ_MASK, 32'h1C3);
		rd_chk("mask readback", bnp_pkg::OFS_IRQ_MASK, 32'hC3);
		wr(bnp_pkg::OFS_LVL_EN, 32'h1A5);
		rd_chk("lvl en readback", bnp_pkg::OFS_LVL_EN, 32'hA5);
		check("lvl oe", {24'h0, gpio_oe}, 32'h0A);
	endtask : t_init

	initial begin
		clock = 1'b0;
		rst_n = 1'b0;
		address = 6'h00;
		read = 1'b0;
		write = 1'b0;
		byteenable = 4'hF;
		writedata = 32'h0;
		ext_val = 8'hFF;
		ext_drv = 8'h00;
		errors = 0;
		tests_run = 0;
		repeat (10) @(posedge clock);
		rst_n <= 1'b1;
		t_byte;
		t_nib;
		t_lvl;
		t_irq;
		t_init;
		wrap_up;
	end
endmodule : bnp_port_tb
